//--- hdl/tis_cfg.svh
`ifndef TIS_CFG_SVH
`define TIS_CFG_SVH

// ----------------------------------------------------------------------
// Clock and timing.
// ----------------------------------------------------------------------
`define TIS_CLK_MHZ 40
`define TIS_TICK_US 1000
`define TIS_CE_FILT_NS 187500

// ----------------------------------------------------------------------
// Timebase periods in milliseconds.
// ----------------------------------------------------------------------
`define TIS_CARRY_PERIOD_MS 8'h64
`define TIS_IRQ_P0_MS 8'h05
`define TIS_IRQ_P1_MS 8'h0A
`define TIS_IRQ_P2_MS 8'h32
`define TIS_IRQ_P3_MS 8'hFA
`define TIS_IRQ_PHASE_MS 8'h01
`define TIS_CNT_ZERO 8'h00
`define TIS_CNT_ONE 8'h01

// ----------------------------------------------------------------------
// Register map and fields.
// ----------------------------------------------------------------------
`define TIS_ADR_CTRL 4'h0
`define TIS_ADR_IRQ 4'h4
`define TIS_ADR_STAT 4'h8
`define TIS_CTRL_PERMIT 0
`define TIS_CTRL_IE 1
`define TIS_CTRL_SEL_LO 2
`define TIS_CTRL_SEL_HI 3
`define TIS_IRQ_PEND 0
`define TIS_STAT_CARRY 0
`define TIS_STAT_CE 1
`define TIS_STAT_HALT 2
`define TIS_STAT_STOP 3
`define TIS_STAT_ARM 4
`define TIS_STAT_W 5
`define TIS_SEL_RST 2'h0
`define TIS_DAT_ZERO 32'h0000_0000

// ----------------------------------------------------------------------
// Halt release condition bits and interrupt vector.
// ----------------------------------------------------------------------
`define TIS_HC_KEY 0
`define TIS_HC_CARRY 1
`define TIS_HC_IRQ 3
`define TIS_HC_RST 4'h0
`define TIS_IRQ_VECTOR 12'h003

`endif

//--- hdl/tis_pkg.sv
package tis_pkg;

   // Standby state of the core: running, halted CPU or stopped clock.
   typedef enum logic [1:0] {
      tis_run  = 2'b00,
      tis_halt = 2'b01,
      tis_stop = 2'b10
   } tis_stby_e;

   typedef logic [1:0] tis_sel_t;

endpackage

//--- hdl/tis_ce_filter.sv
`timescale 1ns/100ps
`include "tis_cfg.svh"

module tis_ce_filter #(
   parameter int FILT_CYC = 7500
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_pin,
   output logic o_level
);

   // ----------------------------------------------------------------------
   // Synchroniser and glitch filter.
   // ----------------------------------------------------------------------
   logic s1_q;
   logic s2_q;
   logic lvl_q;
   logic [15:0] cnt_q;

   // Two flops bring the pin into the clock domain.
   always_ff @(posedge i_clk) begin
      s1_q <= i_pin;
      s2_q <= s1_q;
   end

   // A new level is taken only after it has stood for the whole interval,
   // so short spikes never reach the reset logic.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         lvl_q <= 1'b0;
         cnt_q <= 16'h0000;
      end else if (s2_q == lvl_q) begin
         cnt_q <= 16'h0000;
      end else if (cnt_q == 16'(FILT_CYC - 1)) begin
         lvl_q <= s2_q;
         cnt_q <= 16'h0000;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   assign o_level = lvl_q;

   property p_ce_filter_hold;
      @(posedge i_clk) disable iff (i_sys_rst)
      (lvl_q != $past(lvl_q)) |-> ($past(cnt_q) == 16'(FILT_CYC - 1));
   endproperty
   a_ce_filter_hold: assert property (p_ce_filter_hold)
      else $error("CE level changed before the filter interval elapsed.");

endmodule

//--- hdl/tis_pulse_gen.sv
`timescale 1ns/100ps
`include "tis_cfg.svh"

module tis_pulse_gen #(
   parameter int TICK_CYC = 40000
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_run,
   output logic o_carry_pulse,
   output logic [3:0] o_irq_pulse
);

   // ----------------------------------------------------------------------
   // Millisecond timebase.
   // ----------------------------------------------------------------------
   logic [15:0] pre_q;
   logic tick;
   logic [7:0] car_q;

   // Period of each selectable interrupt pulse.
   function automatic logic [7:0] period_of(input int idx);
      logic [7:0] p;
      p = `TIS_IRQ_P0_MS;
      case (idx)
         1: p = `TIS_IRQ_P1_MS;
         2: p = `TIS_IRQ_P2_MS;
         3: p = `TIS_IRQ_P3_MS;
         default: p = `TIS_IRQ_P0_MS;
      endcase
      return p;
   endfunction

   assign tick = i_run && (pre_q == 16'(TICK_CYC - 1));

   // The prescaler freezes while the oscillator is stopped.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || tick) begin
         pre_q <= 16'h0000;
      end else if (i_run) begin
         pre_q <= pre_q + 16'h0001;
      end
   end

   // Carry set pulse counter starts at phase zero.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         car_q <= `TIS_CNT_ZERO;
      end else if (tick) begin
         if (car_q == `TIS_CARRY_PERIOD_MS - `TIS_CNT_ONE) begin
            car_q <= `TIS_CNT_ZERO;
         end else begin
            car_q <= car_q + `TIS_CNT_ONE;
         end
      end
   end

   assign o_carry_pulse = car_q < (`TIS_CARRY_PERIOD_MS >> 1);

   // ----------------------------------------------------------------------
   // Interrupt pulses, phase shifted against the carry pulse.
   // ----------------------------------------------------------------------
   for (genvar g = 0; g < 4; g++) begin : g_irq
      logic [7:0] cnt_q;
      // Starting one tick ahead keeps every falling edge of these pulses
      // off the falling edge of the carry pulse for all periods.
      always_ff @(posedge i_clk) begin
         if (i_sys_rst) begin
            cnt_q <= `TIS_IRQ_PHASE_MS;
         end else if (tick) begin
            if (cnt_q == period_of(g) - `TIS_CNT_ONE) begin
               cnt_q <= `TIS_CNT_ZERO;
            end else begin
               cnt_q <= cnt_q + `TIS_CNT_ONE;
            end
         end
      end
      assign o_irq_pulse[g] = cnt_q < (period_of(g) >> 1);
   end

   logic car_prev_q;
   logic [3:0] irq_prev_q;

   always_ff @(posedge i_clk) begin
      car_prev_q <= o_carry_pulse;
      irq_prev_q <= o_irq_pulse;
   end

   property p_falls_apart;
      @(posedge i_clk) disable iff (i_sys_rst)
      (car_prev_q && !o_carry_pulse) |-> ((irq_prev_q & ~o_irq_pulse) == 4'h0);
   endproperty
   a_falls_apart: assert property (p_falls_apart)
      else $error("Interrupt pulse fell together with the carry pulse.");

endmodule

//--- hdl/tis_timer_irq_ctrl.sv
// Behaviour
// - Accept timer request on each selected pulse fall when permit and enable set.
// - Accepting any request clears the global interrupt enable until re-enabled.
// - Pulse falls still set the pending flag while interrupts are disabled.
// - Setting the permit with a pending flag gives an immediate acceptance.
// - With nothing pending, first interrupt comes at the next pulse fall.
// - Changing interval without a fall raises nothing until the pulse falls.
// - Changing interval that makes the pulse fall counts as an edge.
// - Software writing one to the pending flag is a real request.
// - Software clear in the same cycle as a pulse fall wins.
// - After CE rises, reset fires at the next carry pulse rising edge without a coincident status read.
// - CE reset beats a timer request arising in the same cycle.
// - CE reset clears the pending flag, discarding the request.
// - Interrupt pulse falls are offset from carry pulse falls.
// - Standby offers a CPU halt and a full clock stop.
// - Halt stops the CPU until a selected release condition or a CE reset occurs.
// - Clock stop halts the crystal oscillator.
// - Clock stop freezes oscillator, CPU, system and control registers.
// - Acceptance jumps to the fixed vector and clears the pending flag.
// - Writing zero to the pending flag cancels the request.
// - Clock stop works only with CE low, else it does nothing.
// - CE levels shorter than the filter interval are ignored.
`timescale 1ns/100ps
`include "tis_cfg.svh"

module tis_timer_irq_ctrl #(
   parameter int TICK_CYC = `TIS_TICK_US * `TIS_CLK_MHZ,
   parameter int CE_FILT_CYC = (`TIS_CE_FILT_NS * `TIS_CLK_MHZ + 999) / 1000
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [3:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic i_ce_pin,
   input wire logic [3:0] i_key,
   input wire logic i_ei_instr,
   input wire logic i_di_instr,
   input wire logic i_halt_instr,
   input wire logic [3:0] i_halt_cond,
   input wire logic i_stop_instr,
   output logic o_irq_take,
   output logic [11:0] o_irq_vector,
   output logic o_cpu_run,
   output logic o_cpu_halt,
   output logic o_osc_stop,
   output logic o_ce_reset,
   output logic o_ce_level
);

   // ----------------------------------------------------------------------
   // Declarations.
   // ----------------------------------------------------------------------
   tis_pkg::tis_stby_e state_q;
   tis_pkg::tis_sel_t sel_q;
   logic ack_q;
   logic [31:0] rdat_q;
   logic permit_q;
   logic ie_q;
   logic pending_q;
   logic carry_flag_q;
   logic arm_q;
   logic ce_prev_q;
   logic car_prev_q;
   logic sel_prev_q;
   logic ce_rst_q;
   logic [3:0] halt_cond_q;
   logic [3:0] key1_q;
   logic [3:0] key2_q;
   logic ce_lvl;
   logic carry_pulse;
   logic [3:0] irq_pulse;
   logic sel_pulse;
   logic fall;
   logic ce_rise;
   logic carry_rise;
   logic fire;
   logic take;
   logic stopped;
   logic acc;
   logic wr;
   logic rd;
   logic wr_ctrl;
   logic wr_irq;
   logic stat_rd;
   logic halt_rel;

   // Address match, shared by the write and read paths.
   function automatic logic hit(input logic [3:0] adr, input logic [3:0] off);
      return adr == off;
   endfunction

   // ----------------------------------------------------------------------
   // Sub blocks.
   // ----------------------------------------------------------------------
   tis_ce_filter #(
      .FILT_CYC(CE_FILT_CYC)
   ) u_ce_filter (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_pin(i_ce_pin),
      .o_level(ce_lvl)
   );

   tis_pulse_gen #(
      .TICK_CYC(TICK_CYC)
   ) u_pulse_gen (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_run(!stopped),
      .o_carry_pulse(carry_pulse),
      .o_irq_pulse(irq_pulse)
   );

   // Key pins come from outside and pass two flops first.
   always_ff @(posedge i_clk) begin
      key1_q <= i_key;
      key2_q <= key1_q;
   end

   // ----------------------------------------------------------------------
   // Wishbone slave.
   // ----------------------------------------------------------------------
   assign acc = i_wb_cyc && i_wb_stb;
   assign stopped = (state_q == tis_pkg::tis_stop);
   // Writes land at the ack edge; a stopped clock freezes the control
   // register, so writes are acknowledged but dropped.
   assign wr = acc && i_wb_we && ack_q && i_wb_sel[0] && !stopped;
   assign rd = acc && !i_wb_we && ack_q;
   assign wr_ctrl = wr && hit(i_wb_adr, `TIS_ADR_CTRL);
   assign wr_irq = wr && hit(i_wb_adr, `TIS_ADR_IRQ);
   assign stat_rd = rd && hit(i_wb_adr, `TIS_ADR_STAT);

   // One wait state, then ack for one cycle.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= acc && !ack_q;
      end
   end

   // Read data is captured in the cycle before ack; unmapped reads zero.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         rdat_q <= `TIS_DAT_ZERO;
      end else if (acc && !ack_q) begin
         rdat_q <= `TIS_DAT_ZERO;
         if (hit(i_wb_adr, `TIS_ADR_CTRL)) begin
            rdat_q[`TIS_CTRL_PERMIT] <= permit_q;
            rdat_q[`TIS_CTRL_IE] <= ie_q;
            rdat_q[`TIS_CTRL_SEL_HI:`TIS_CTRL_SEL_LO] <= sel_q;
         end else if (hit(i_wb_adr, `TIS_ADR_IRQ)) begin
            rdat_q[`TIS_IRQ_PEND] <= pending_q;
         end else if (hit(i_wb_adr, `TIS_ADR_STAT)) begin
            rdat_q[`TIS_STAT_W-1:0] <= {arm_q, stopped,
               state_q == tis_pkg::tis_halt, ce_lvl, carry_flag_q};
         end
      end
   end

   assign o_wb_dat = rdat_q;
   assign o_wb_ack = ack_q;

   // ----------------------------------------------------------------------
   // Control register: permit and interval selection.
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || fire) begin
         permit_q <= 1'b0;
         sel_q <= `TIS_SEL_RST;
      end else if (wr_ctrl) begin
         permit_q <= i_wb_dat[`TIS_CTRL_PERMIT];
         sel_q <= i_wb_dat[`TIS_CTRL_SEL_HI:`TIS_CTRL_SEL_LO];
      end
   end

   // ----------------------------------------------------------------------
   // Edge detection on the selected interrupt pulse.
   // ----------------------------------------------------------------------
   assign sel_pulse = irq_pulse[sel_q];

   // The previous sample is taken after the selector, so a switch from a
   // high pulse to a low one reads as a fall and low to high does not.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         sel_prev_q <= 1'b0;
      end else begin
         sel_prev_q <= sel_pulse;
      end
   end

   assign fall = sel_prev_q && !sel_pulse;

   // ----------------------------------------------------------------------
   // Pending flag and acceptance.
   // ----------------------------------------------------------------------
   // Acceptance is immediate from the stored flag, so a late permit or a
   // software set is taken without waiting for another edge.
   assign take = pending_q && permit_q && ie_q && !fire;

   // Priority: CE reset, software clear, new request, acceptance. The clear
   // beating a coincident fall is deliberate; a new fall beats acceptance.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         pending_q <= 1'b0;
      end else if (fire) begin
         pending_q <= 1'b0;
      end else if (wr_irq && !i_wb_dat[`TIS_IRQ_PEND]) begin
         pending_q <= 1'b0;
      end else if (fall || (wr_irq && i_wb_dat[`TIS_IRQ_PEND])) begin
         pending_q <= 1'b1;
      end else if (take) begin
         pending_q <= 1'b0;
      end
   end

   // Global enable: acceptance disables, enable instruction sets.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || fire) begin
         ie_q <= 1'b0;
      end else if (take) begin
         ie_q <= 1'b0;
      end else if (i_ei_instr) begin
         ie_q <= 1'b1;
      end else if (i_di_instr) begin
         ie_q <= 1'b0;
      end
   end

   assign o_irq_take = take;
   assign o_irq_vector = `TIS_IRQ_VECTOR;

   // ----------------------------------------------------------------------
   // Timer carry flag and CE reset.
   // ----------------------------------------------------------------------
   assign ce_rise = ce_lvl && !ce_prev_q;
   assign carry_rise = carry_pulse && !car_prev_q;
   // A status read in the same cycle as the carry edge defers the reset to
   // the following carry edge.
   assign fire = arm_q && carry_rise && !stat_rd;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ce_prev_q <= 1'b0;
         car_prev_q <= 1'b1; // Carry pulse idles high, no false edge.
         ce_rst_q <= 1'b0;
      end else begin
         ce_prev_q <= ce_lvl;
         car_prev_q <= carry_pulse;
         ce_rst_q <= fire;
      end
   end

   // The set from the carry edge wins over a read-clear.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         carry_flag_q <= 1'b0;
      end else if (carry_rise) begin
         carry_flag_q <= 1'b1;
      end else if (stat_rd) begin
         carry_flag_q <= 1'b0;
      end
   end

   // The filtered CE rise arms the reset; the carry edge fires it.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         arm_q <= 1'b0;
      end else if (ce_rise) begin
         arm_q <= 1'b1;
      end else if (fire) begin
         arm_q <= 1'b0;
      end
   end

   assign o_ce_reset = ce_rst_q;
   assign o_ce_level = ce_lvl;

   // ----------------------------------------------------------------------
   // Standby: halt and clock stop.
   // ----------------------------------------------------------------------
   assign halt_rel = (halt_cond_q[`TIS_HC_KEY] && (key2_q != 4'h0))
      || (halt_cond_q[`TIS_HC_CARRY] && carry_flag_q)
      || (halt_cond_q[`TIS_HC_IRQ] && take);

   // Halt keeps peripherals running; stop also freezes the timebase. Only
   // a CE rise leaves stop, since no timer edge can come while stopped.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state_q <= tis_pkg::tis_run;
         halt_cond_q <= `TIS_HC_RST;
      end else begin
         unique case (state_q)
            tis_pkg::tis_run: begin
               if (i_stop_instr && !ce_lvl) begin
                  state_q <= tis_pkg::tis_stop;
               end else if (i_halt_instr) begin
                  state_q <= tis_pkg::tis_halt;
                  halt_cond_q <= i_halt_cond;
               end
            end
            tis_pkg::tis_halt: begin
               if (halt_rel || fire) begin
                  state_q <= tis_pkg::tis_run;
               end
            end
            tis_pkg::tis_stop: begin
               if (ce_rise) begin
                  state_q <= tis_pkg::tis_run;
               end
            end
            default: begin
               state_q <= tis_pkg::tis_run;
            end
         endcase
      end
   end

   assign o_cpu_halt = (state_q == tis_pkg::tis_halt);
   assign o_osc_stop = stopped;
   assign o_cpu_run = (state_q == tis_pkg::tis_run);

   // ----------------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------------
   property p_take_disables;
      @(posedge i_clk) disable iff (i_sys_rst)
      take |=> !ie_q ##1 (!ie_q || $past(i_ei_instr));
   endproperty
   a_take_disables: assert property (p_take_disables)
      else $error("Global enable still set after acceptance.");

   property p_fall_held;
      @(posedge i_clk) disable iff (i_sys_rst)
      (fall && !ie_q && !wr_irq && !fire) |=> pending_q;
   endproperty
   a_fall_held: assert property (p_fall_held)
      else $error("Pulse fall while disabled did not set pending.");

   property p_clear_wins;
      @(posedge i_clk) disable iff (i_sys_rst)
      (wr_irq && !i_wb_dat[`TIS_IRQ_PEND] && fall) |=> !pending_q;
   endproperty
   a_clear_wins: assert property (p_clear_wins)
      else $error("Coincident pulse fall beat the software clear.");

   property p_set_taken;
      @(posedge i_clk) disable iff (i_sys_rst)
      (wr_irq && i_wb_dat[`TIS_IRQ_PEND] && permit_q && ie_q
         && !fire && !i_di_instr && !carry_rise && !take) |=> take;
   endproperty
   a_set_taken: assert property (p_set_taken)
      else $error("Software set was not accepted next cycle.");

   property p_permit_immediate;
      @(posedge i_clk) disable iff (i_sys_rst)
      ($rose(permit_q) && pending_q && ie_q && !fire) |-> take;
   endproperty
   a_permit_immediate: assert property (p_permit_immediate)
      else $error("Pending request not taken when permit rose.");

   property p_reset_on_carry;
      @(posedge i_clk) disable iff (i_sys_rst)
      o_ce_reset |-> $past(carry_rise) && $past(arm_q) && !pending_q;
   endproperty
   a_reset_on_carry: assert property (p_reset_on_carry)
      else $error("CE reset not tied to a carry edge or pending survived.");

   property p_reset_first;
      @(posedge i_clk) disable iff (i_sys_rst)
      fire |-> !take ##1 !take;
   endproperty
   a_reset_first: assert property (p_reset_first)
      else $error("Interrupt accepted alongside a CE reset.");

   property p_stop_ce_high;
      @(posedge i_clk) disable iff (i_sys_rst)
      (state_q == tis_pkg::tis_run && i_stop_instr && ce_lvl) |=> !stopped;
   endproperty
   a_stop_ce_high: assert property (p_stop_ce_high)
      else $error("Clock stop taken while CE was high.");

   property p_take_vector;
      @(posedge i_clk) disable iff (i_sys_rst)
      take |-> (o_irq_vector == `TIS_IRQ_VECTOR) ##1 (!pending_q || $past(fall)
         || $past(wr_irq));
   endproperty
   a_take_vector: assert property (p_take_vector)
      else $error("Acceptance left pending set or wrong vector.");

endmodule

//--- testbench/tis_cpu_model.sv
`timescale 1ns/100ps
// Stands in for the instruction sequencer and the CE pin driver.
module tis_cpu_model (
   input wire logic i_clk,
   output logic o_ei,
   output logic o_di,
   output logic o_halt,
   output logic [3:0] o_cond,
   output logic o_stop,
   output logic o_ce
);
   // Idle pins; no release condition, so only a reset ends a halt.
   initial begin
      o_ei = 1'b0;
      o_di = 1'b0;
      o_halt = 1'b0;
      o_cond = 4'h0;
      o_stop = 1'b0;
      o_ce = 1'b0;
   end

   // One-cycle instruction pulse: 0 enable, 1 halt, 3 disable, else stop.
   task automatic instr(input int k);
      @(posedge i_clk);
      case (k)
         0: o_ei <= 1'b1;
         1: o_halt <= 1'b1;
         3: o_di <= 1'b1;
         default: o_stop <= 1'b1;
      endcase
      @(posedge i_clk);
      o_ei <= 1'b0;
      o_di <= 1'b0;
      o_halt <= 1'b0;
      o_stop <= 1'b0;
   endtask

   // Release condition for the next halt, held until changed.
   task automatic set_cond(input logic [3:0] c);
      @(posedge i_clk);
      o_cond <= c;
   endtask

   // CE level change, held as long as the bench wants.
   task automatic set_ce(input logic v);
      @(posedge i_clk);
      o_ce <= v;
   endtask
endmodule

//--- testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, o_wb_dat;
   logic o_wb_ack, o_irq_take, o_cpu_run, o_cpu_halt, o_osc_stop;
   logic o_ce_reset, o_ce_level, ei, di, hlt, stp, ce;
   logic [3:0] hc, key = 4'h0, sel = 4'h0, msk = 4'hF;
   logic [11:0] o_irq_vector;
   int bad_count = 0, samples_checked = 0, takes = 0, n, m;

   // 40 MHz clock.
   always #12.5 i_clk = ~i_clk;

   // Small tick and filter counts keep the run short.
   tis_timer_irq_ctrl #(.TICK_CYC(4), .CE_FILT_CYC(3)) i_tis_timer_irq_ctrl (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(cyc), .i_wb_stb(cyc),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
      .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_ce_pin(ce),
      .i_key(key), .i_ei_instr(ei), .i_di_instr(di), .i_halt_instr(hlt),
      .i_halt_cond(hc), .i_stop_instr(stp), .o_irq_take(o_irq_take),
      .o_irq_vector(o_irq_vector), .o_cpu_run(o_cpu_run),
      .o_cpu_halt(o_cpu_halt), .o_osc_stop(o_osc_stop),
      .o_ce_reset(o_ce_reset), .o_ce_level(o_ce_level));

   tis_cpu_model i_tis_cpu_model (.i_clk(i_clk), .o_ei(ei), .o_di(di),
      .o_halt(hlt), .o_cond(hc), .o_stop(stp), .o_ce(ce));

   // Counts acceptances so that a stray one is noticed.
   always @(posedge i_clk) begin
      if (o_irq_take === 1'b1) takes++;
   end

   task automatic results;
      $display("checks %0d errors %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Classic single Wishbone cycle; waits for ack under a bound.
   task automatic wb(input logic w, input logic [3:0] a, input int d);
      @(posedge i_clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= msk;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_wb_ack !== 1'b1 && n < 50);
      rdat = o_wb_dat;
      cyc <= 1'b0;
      if (n >= 50) begin
         bad_count++;
         results();
      end
   endtask

   // Bounded wait for a design output to reach a level.
   task automatic wt(ref logic s, input logic v);
      n = 0;
      while (s !== v && n < 3000) begin
         @(posedge i_clk);
         n++;
      end
      if (n >= 3000) begin
         bad_count++;
         results();
      end
   endtask

   initial begin
      repeat (5) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_clk);
      chk(o_cpu_run, 1);
      chk(o_irq_vector, 12'h003);
      // Longest interval, permit off, enable off: pulses still pend.
      wb(1, 4'h0, 'hC);
      rdat = 32'h0;
      for (m = 0; m < 2000 && rdat[0] !== 1'b1; m++) wb(0, 4'h4, 0);
      chk(rdat[3:0], 1);
      chk(takes[11:0], 0);
      wb(1, 4'h4, 0);
      wb(0, 4'h4, 0);
      chk(rdat[3:0], 0);
      // Software-set pend, then permit after enable: taken at once.
      wb(1, 4'h4, 1);
      i_tis_cpu_model.instr(0);
      chk(takes[11:0], 0);
      wb(1, 4'h0, 'hD);
      wt(o_irq_take, 1'b1);
      chk(n[11:0], 1);
      wb(0, 4'h0, 0);
      chk(rdat[3:0], 4'hD);
      wb(0, 4'h4, 0);
      chk(rdat[3:0], 0);
      // Nothing pending: next pulse fall gives the next acceptance.
      i_tis_cpu_model.instr(0);
      wt(o_irq_take, 1'b1);
      @(posedge i_clk);
      chk(takes[11:0], 2);
      // Disable clears the enable; a software set while enabled is taken.
      i_tis_cpu_model.instr(0);
      wb(0, 4'h0, 0);
      chk(rdat[3:0], 4'hF);
      i_tis_cpu_model.instr(3);
      wb(0, 4'h0, 0);
      chk(rdat[3:0], 4'hD);
      i_tis_cpu_model.instr(0);
      wb(1, 4'h4, 1);
      wt(o_irq_take, 1'b1);
      chk(n[11:0], 1);
      @(posedge i_clk);
      chk(takes[11:0], 3);
      // Halt with the key condition is released by a key level.
      i_tis_cpu_model.set_cond(4'h1);
      i_tis_cpu_model.instr(1);
      @(posedge i_clk);
      chk(o_cpu_halt, 1);
      key <= 4'h2;
      repeat (4) @(posedge i_clk);
      chk(o_cpu_halt, 0);
      key <= 4'h0;
      i_tis_cpu_model.set_cond(4'h0);
      // Halt, then CE rise: carry-aligned reset releases and clears.
      i_tis_cpu_model.instr(1);
      @(posedge i_clk);
      chk(o_cpu_halt, 1);
      i_tis_cpu_model.set_ce(1'b1);
      wt(o_ce_reset, 1'b1);
      @(posedge i_clk);
      chk(o_cpu_halt, 0);
      wb(0, 4'h0, 0);
      chk(rdat[3:0], 0);
      // A write without the low byte lane leaves the permit off.
      msk = 4'hE;
      wb(1, 4'h0, 'h1);
      msk = 4'hF;
      wb(0, 4'h0, 0);
      chk(rdat[3:0], 0);
      // Carry flag set by the firing edge, CE high, arm spent; read clears.
      wb(0, 4'h8, 0);
      chk(rdat[4:0], 5'h03);
      wb(0, 4'h8, 0);
      chk(rdat[4:0], 5'h02);
      i_tis_cpu_model.instr(2);
      @(posedge i_clk);
      chk(o_osc_stop, 0);
      i_tis_cpu_model.set_ce(1'b0);
      wt(o_ce_level, 1'b0);
      // A one-cycle CE blip is shorter than the filter.
      i_tis_cpu_model.set_ce(1'b1);
      i_tis_cpu_model.set_ce(1'b0);
      repeat (10) @(posedge i_clk);
      chk(o_ce_level, 0);
      i_tis_cpu_model.instr(2);
      @(posedge i_clk);
      chk(o_osc_stop, 1);
      chk(o_cpu_run, 0);
      i_tis_cpu_model.set_ce(1'b1);
      wt(o_osc_stop, 1'b0);
      results();
   end
endmodule
